/* File: rtl/simo_dcdc_ctrl.sv */
// Purpose: digital control of a four-output single-inductor buck converter
// Assumes: comparator and detector inputs are asynchronous to clk
// Notes:   outputs 0 and 1 are the two 1.8 V rails
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "simo_cfg.svh"

module simo_dcdc_ctrl #(
   parameter int LIM_W = 5,            // current limit field width
   parameter int CNT_W = 16            // hold time counter width
) (
   input  wire logic        clk,       // 40 MHz clock
   input  wire logic        reset,     // synchronous, active high
   input  wire logic        ce,        // clock enable, freezes all state
   input  wire logic [7:0]  wb_adr_i,  // byte address
   input  wire logic [31:0] wb_dat_i,  // write data
   output logic      [31:0] wb_dat_o,  // read data
   input  wire logic        wb_we_i,   // write enable
   input  wire logic [3:0]  wb_sel_i,  // byte lanes
   input  wire logic        wb_cyc_i,  // cycle
   input  wire logic        wb_stb_i,  // strobe
   output logic             wb_ack_o,  // acknowledge
   input  wire logic [3:0]  belowMin,  // clocked comparators, rail low
   input  wire logic        batLow,    // battery below 2.45 V detector
   input  wire logic        busAboveBat, // bus supply above battery
   input  wire logic        sleepTick, // sleep clock tick, async
   output logic             chargeReq, // charge cycle running
   output logic      [1:0]  chargeRail, // rail being charged
   output logic [LIM_W-1:0] currentLimit, // applied current limit
   output logic      [3:0]  railEnable, // converter outputs enabled
   output logic             lowVoltageMode, // enable 1.8 V LDOs
   output logic             batteryBrownoutEnable, // detector enable
   output logic             brownoutIrq, // interrupt, level
   output logic             bandgapOn, // bandgap running
   output logic             retentionSample, // LDO reference resample
   output logic             busPoweredRegulator // bus powered LDO on
);

   // two-stage synchronisers for every asynchronous input (comparators, detectors, sleep tick)
   logic [3:0] belowS1_ff, belowS2_ff;
   logic [2:0] miscS1_ff, miscS2_ff;
   logic       tickOld_ff;
   always_ff @(posedge clk) begin
      if (reset) begin
         belowS1_ff <= 4'h0;
         belowS2_ff <= 4'h0;
         miscS1_ff  <= 3'h0;
         miscS2_ff  <= 3'h0;
         tickOld_ff <= 1'b0;
      end else if (ce) begin
         belowS1_ff <= belowMin;
         belowS2_ff <= belowS1_ff;
         miscS1_ff  <= {sleepTick, busAboveBat, batLow};
         miscS2_ff  <= miscS1_ff;
         tickOld_ff <= miscS2_ff[2];
      end
   end
   wire logic [3:0] railLow = belowS2_ff;
   wire logic       batLowS = miscS2_ff[0];
   wire logic       busHigh = miscS2_ff[1];
   // the tick edge is found after the second flop, never on the first
   wire logic       tickEv  = miscS2_ff[2] & ~tickOld_ff;

   // registers
   simo_pkg::simo_ctrl_s ctrl_ff;
   logic [7:0]       prio_ff;
   logic [LIM_W-1:0] limit_ff, lvLim_ff, maxLim_ff;
   logic [15:0]      slpPeriod_ff;
   logic [CNT_W-1:0] longThr_ff, shortThr_ff;
   logic             lv_ff, irqSt_ff, irqMask_ff, ack_ff;
   logic [31:0]      rdat_ff;

   // bus decode, single-cycle answer after each request
   // the ack flop blocks a second take while the master still holds stb
   wire logic req     = wb_cyc_i & wb_stb_i & ~ack_ff;
   wire logic wrEn    = req & wb_we_i & wb_sel_i[0];
   wire logic wrCtrl  = wrEn && wb_adr_i == `SIMO_CTRL_ADDR;
   wire logic wrPrio  = wrEn && wb_adr_i == `SIMO_PRIO_ADDR;
   wire logic wrLimit = wrEn && wb_adr_i == `SIMO_LIMIT_ADDR;
   wire logic wrLvLim = wrEn && wb_adr_i == `SIMO_LVLIM_ADDR;
   wire logic wrMask  = wrEn && wb_adr_i == `SIMO_IRQMASK_ADDR;
   wire logic wrClr   = wrEn && wb_adr_i == `SIMO_IRQCLR_ADDR;
   wire logic wrSlp   = wrEn && wb_adr_i == `SIMO_SLPTIM_ADDR;
   wire logic wrThr   = wrEn && wb_adr_i == `SIMO_THRESH_ADDR;
   wire logic autoOff = wrCtrl & ~wb_dat_i[`SIMO_CTRL_AUTO_LV];

   // brown-out only seen while software enables the detector
   wire logic bodEvent = ctrl_ff.bodEn & batLowS;            // [R5]
   logic bodOld_ff;
   wire logic bodRise = bodEvent & ~bodOld_ff;

   // read mux
   logic [31:0] rdMux;
   always_comb begin
      rdMux = 32'h0000_0000;
      unique case (wb_adr_i)
         `SIMO_CTRL_ADDR:    rdMux = {24'h00_0000, ctrl_ff.railEn,
                                1'b0, ctrl_ff.autoLv, ctrl_ff.bodEn,
                                ctrl_ff.active};
         `SIMO_PRIO_ADDR:    rdMux = {24'h00_0000, prio_ff};
         `SIMO_LIMIT_ADDR:   rdMux = 32'(limit_ff);
         `SIMO_LVLIM_ADDR:   rdMux = 32'(lvLim_ff);
         `SIMO_STATUS_ADDR:  rdMux = {27'h000_0000, bandgapOn, busHigh,
                                batLowS, irqSt_ff, lv_ff};
         `SIMO_IRQMASK_ADDR: rdMux = {31'h0000_0000, irqMask_ff};
         `SIMO_SLPTIM_ADDR:  rdMux = {16'h0000, slpPeriod_ff};
         `SIMO_THRESH_ADDR:  rdMux = {16'(longThr_ff), 16'(shortThr_ff)};
         default:            rdMux = 32'h0000_0000;
      endcase
   end

   // register writes; unmapped writes are acknowledged and dropped
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_ff      <= '0;
         prio_ff      <= `SIMO_PRIO_RST;
         maxLim_ff    <= LIM_W'(`SIMO_LIMIT_RST);
         lvLim_ff     <= LIM_W'(`SIMO_LVLIM_RST);
         irqMask_ff   <= 1'b0;
         slpPeriod_ff <= 16'h0000;
         longThr_ff   <= CNT_W'(`SIMO_LONG_RST);
         shortThr_ff  <= CNT_W'(`SIMO_SHORT_RST);
         ack_ff       <= 1'b0;
         rdat_ff      <= 32'h0000_0000;
      end else if (ce) begin
         ack_ff  <= req;
         rdat_ff <= rdMux;
         if (wrCtrl) begin
            ctrl_ff.active <= wb_dat_i[`SIMO_CTRL_ACTIVE];
            ctrl_ff.bodEn  <= wb_dat_i[`SIMO_CTRL_BOD_EN];
            ctrl_ff.autoLv <= wb_dat_i[`SIMO_CTRL_AUTO_LV];
            ctrl_ff.railEn <= wb_dat_i[`SIMO_CTRL_RAIL_LSB +: 4];
         end
         if (wrPrio)  prio_ff    <= wb_dat_i[7:0];
         if (wrLimit) maxLim_ff  <= wb_dat_i[LIM_W-1:0];
         if (wrLvLim) lvLim_ff   <= wb_dat_i[LIM_W-1:0];
         if (wrMask)  irqMask_ff <= wb_dat_i[0];
         if (wrSlp && wb_sel_i[1])
            slpPeriod_ff <= wb_dat_i[15:0];
         if (wrThr && wb_sel_i[3]) begin
            shortThr_ff <= CNT_W'(wb_dat_i[15:0]);
            longThr_ff  <= CNT_W'(wb_dat_i[31:16]);
         end
      end
   end
   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdat_ff;

   // low voltage mode is sticky; only a zero written to auto enable ends it
   // interrupt path is separate so it fires with auto mode on or off
   always_ff @(posedge clk) begin
      if (reset) begin
         lv_ff     <= 1'b0;
         irqSt_ff  <= 1'b0;
         bodOld_ff <= 1'b0;
      end else if (ce) begin
         bodOld_ff <= bodEvent;
         if (autoOff)
            lv_ff <= 1'b0;                                      // [R9] [R10]
         else if (ctrl_ff.autoLv & bodEvent)
            lv_ff <= 1'b1;                                      // [R6] [R8]
         if (bodRise)
            irqSt_ff <= 1'b1;                                   // [R11] [R12]
         else if (wrClr & wb_dat_i[0])
            irqSt_ff <= 1'b0;                                   // [R11]
      end
   end
   assign brownoutIrq = irqSt_ff & ~irqMask_ff;                 // [R11]
   assign lowVoltageMode = lv_ff;                               // [R7]
   assign batteryBrownoutEnable = ctrl_ff.bodEn;                // [R5]
   assign railEnable = ctrl_ff.railEn & (lv_ff ? 4'hC : 4'hF);  // [R6]
   assign busPoweredRegulator = busHigh;                        // [R15]

   // priority sort: slot k of the priority register names a rail
   function automatic logic [7:0] sort_rails(input logic [7:0] prio,
                                             input logic [3:0] need);
      logic [7:0] seq;
      logic [2:0] n;
      seq = 8'h00;
      n = 3'h0;
      for (int k = 0; k < 4; k++) begin
         if (need[prio[2*k +: 2]]) begin
            seq[2*n[1:0] +: 2] = prio[2*k +: 2];
            n = n + 3'h1;
         end
      end
      return seq;
   endfunction

   // ones in the low n places: marks the live slots of the shift chain
   function automatic logic [3:0] live_slots(input int n);
      logic [4:0] m;
      m = (5'h01 << n) - 5'h01;
      return m[3:0];
   endfunction

   // charge sequencer: four-entry shift chain of rail numbers
   simo_pkg::simo_seq_e state_ff;
   logic [7:0] chain_ff;
   logic [3:0] valid_ff;
   // disabled rails never enter the chain, whatever their comparator says
   wire logic [3:0] need = railLow & railEnable;                // [R1]
   wire logic [1:0] head = chain_ff[1:0];
   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= simo_pkg::SIMO_IDLE;
         chain_ff <= 8'h00;
         valid_ff <= 4'h0;
      end else if (ce) begin
         unique case (state_ff)
            simo_pkg::SIMO_IDLE: if (|need) begin
               // a rail still low after its turn is sorted again here
               chain_ff <= sort_rails(prio_ff, need);           // [R2]
               valid_ff <= live_slots($countones(need));        // [R2]
               state_ff <= simo_pkg::SIMO_LOAD;
            end
            simo_pkg::SIMO_LOAD:
               state_ff <= simo_pkg::SIMO_CHARGE;
            simo_pkg::SIMO_CHARGE: begin
               chain_ff <= {2'b00, chain_ff[7:2]};              // [R2]
               // the live mask shifts with the chain; its next slot decides
               valid_ff <= {1'b0, valid_ff[3:1]};
               state_ff <= valid_ff[1] ? simo_pkg::SIMO_LOAD
                                       : simo_pkg::SIMO_IDLE;
            end
         endcase
      end
   end
   assign chargeReq  = state_ff == simo_pkg::SIMO_CHARGE;       // [R1]
   assign chargeRail = head;

   // adaptive limit: time above minimum after each charge of that rail
   logic [CNT_W-1:0] hold_ff [4];
   logic [3:0]       armed_ff;
   logic             tooLong, tooShort;
   always_comb begin
      tooLong  = 1'b0;
      tooShort = 1'b0;
      for (int r = 0; r < 4; r++) begin
         if (armed_ff[r] && railLow[r] && hold_ff[r] < shortThr_ff)
            tooShort = 1'b1;
         if (armed_ff[r] && !railLow[r] && hold_ff[r] == longThr_ff)
            tooLong = 1'b1;
      end
   end
   wire logic [LIM_W-1:0] ceil = lv_ff ? lvLim_ff : maxLim_ff;  // [R6]
   always_ff @(posedge clk) begin
      if (reset) begin
         armed_ff <= 4'h0;
         limit_ff <= LIM_W'(`SIMO_LIMIT_RST);
         for (int r = 0; r < 4; r++) hold_ff[r] <= '0;
      end else if (ce) begin
         for (int r = 0; r < 4; r++) begin
            if (chargeReq && head == 2'(r)) begin
               armed_ff[r] <= 1'b1;
               hold_ff[r]  <= '0;
            end else if (armed_ff[r]) begin
               if (railLow[r] || hold_ff[r] == longThr_ff)
                  armed_ff[r] <= 1'b0;
               hold_ff[r] <= hold_ff[r] + CNT_W'(1);
            end
         end
         // a lowered ceiling pulls the limit down at once; when a rail is
         // quick and another rail slow in one cycle the increase wins
         if (limit_ff > ceil)
            limit_ff <= ceil;
         else if (ctrl_ff.active && tooShort && limit_ff != ceil)
            limit_ff <= limit_ff + LIM_W'(1);                   // [R4] [R18]
         else if (ctrl_ff.active && !tooShort && tooLong
                  && limit_ff != '0)
            limit_ff <= limit_ff - LIM_W'(1);                   // [R3] [R18]
      end
   end
   assign currentLimit = limit_ff;

   // sleep tick timer; zero period disables refresh entirely
   // an expiry during a running refresh is skipped, so a period shorter
   // than the refresh window still lets each refresh resample and stop
   logic [15:0] tickCnt_ff;
   logic [3:0]  bgCnt_ff;
   wire logic   periodEnd = slpPeriod_ff != 16'h0000
                            && tickCnt_ff + 16'h0001 >= slpPeriod_ff;
   always_ff @(posedge clk) begin
      if (reset) begin
         tickCnt_ff <= 16'h0000;
         bgCnt_ff   <= 4'h0;
      end else if (ce && tickEv) begin
         if (slpPeriod_ff == 16'h0000 || periodEnd)
            tickCnt_ff <= 16'h0000;                             // [R17]
         else
            tickCnt_ff <= tickCnt_ff + 16'h0001;
         if (bgCnt_ff != 4'h0)
            bgCnt_ff <= bgCnt_ff - 4'h1;                        // [R14]
         else if (periodEnd)
            bgCnt_ff <= `SIMO_BG_TICKS;                         // [R14] [R16]
      end
   end
   assign bandgapOn       = bgCnt_ff != 4'h0;                   // [R14]
   assign retentionSample = bgCnt_ff == 4'h1;                   // [R14]

endmodule // simo_dcdc_ctrl

/* File: rtl/simo_cfg.svh */
// Purpose: register map, field positions, reset values and timing counts
// Assumes: classic wishbone, 32-bit data, word aligned registers
// Notes:   included by the controller and by the bench
// Functional notes
// [R1] an output below its minimum, seen by its comparator, starts a charge cycle
// [R2] simultaneous requests are sorted by priority into a four-entry shift chain
// [R3] active mode: long time above minimum lowers the current limit one LSB
// [R4] active mode: quick fall below minimum raises the current limit one LSB
// [R5] brown-out below 2.45 V flags only when software enables the detector
// [R6] hardware mode brown-out disables both 1.8 V outputs and lowers limits
// [R7] low voltage mode drives an indication that enables the 1.8 V LDOs
// [R8] low voltage mode stays until software acts, battery recovery ignored
// [R9] writing 0 to auto switch enable disables it and forces high voltage mode
// [R10] software clears then sets auto switch enable to re-arm after recovery
// [R11] brown-out raises an interrupt with a clear and a mask register
// [R12] interrupt and automatic low voltage mode are independent
// [R13] software enables replacement LDOs before disabling the converter
// [R14] sleep tick timer periodically runs bandgap and LDO resample, then stops
// [R15] bus powered LDO switches on when bus supply exceeds battery
// [R16] recommended sleep setup programs a nonzero sleep timer period
// [R17] without sample-hold rails in sleep, software leaves the timer at zero
// [R18] adaptive current limit saturates at field minimum and maximum; the increase stops at maxLim_ff, or lvLim_ff in low voltage mode
`ifndef SIMO_CFG_SVH
`define SIMO_CFG_SVH

// byte offsets
`define SIMO_CTRL_ADDR      8'h00
`define SIMO_PRIO_ADDR      8'h04
`define SIMO_LIMIT_ADDR     8'h08
`define SIMO_LVLIM_ADDR     8'h0C
`define SIMO_STATUS_ADDR    8'h10
`define SIMO_IRQMASK_ADDR   8'h14
`define SIMO_IRQCLR_ADDR    8'h18
`define SIMO_SLPTIM_ADDR    8'h1C
`define SIMO_THRESH_ADDR    8'h20

// control fields
`define SIMO_CTRL_ACTIVE    0
`define SIMO_CTRL_BOD_EN    1
`define SIMO_CTRL_AUTO_LV   2
`define SIMO_CTRL_RAIL_LSB  4

// status fields
`define SIMO_ST_LV          0
`define SIMO_ST_IRQ         1
`define SIMO_ST_BOD         2
`define SIMO_ST_USB         3
`define SIMO_ST_BG          4

// reset values
`define SIMO_PRIO_RST       8'hE4
`define SIMO_LIMIT_RST      5'h10
`define SIMO_LVLIM_RST      5'h08
`define SIMO_LONG_RST       16'h0100
`define SIMO_SHORT_RST      16'h0010

// bandgap refresh, counted in sleep ticks
`define SIMO_BG_TICKS       4'h3

`endif

/* File: rtl/simo_pkg.sv */
// Purpose: shared types of the converter controller
// Assumes: four converter outputs
// Notes:   constants live in simo_cfg.svh
package simo_pkg;
   typedef enum logic [1:0] {SIMO_IDLE, SIMO_LOAD, SIMO_CHARGE} simo_seq_e;
   typedef struct packed {
      logic       active;   // active mode, adaptive limit on
      logic       bodEn;    // battery brown-out enable
      logic       autoLv;   // auto low voltage switch enable
      logic [3:0] railEn;   // per output converter enable
   } simo_ctrl_s;
endpackage

/* File: verif/simo_asserts.sv */
// Purpose: port level checks of the converter controller
// Assumes: ce held high; a bus write lands on the edge that raises ack
// Notes:   bound into every instance of the controller
`timescale 1ns/1ps
module simo_asserts #(
   parameter int LIM_W = 5                      // current limit width
) (
   input wire logic             clk,            // clock
   input wire logic             reset,          // sync reset
   input wire logic [7:0]       wb_adr_i,       // address
   input wire logic [31:0]      wb_dat_i,       // write data
   input wire logic             wb_we_i,        // write enable
   input wire logic [3:0]       wb_sel_i,       // byte lanes
   input wire logic             wb_cyc_i,       // cycle
   input wire logic             wb_stb_i,       // strobe
   input wire logic             wb_ack_o,       // acknowledge
   input wire logic             busAboveBat,    // bus sense
   input wire logic             chargeReq,      // charge slot
   input wire logic [LIM_W-1:0] currentLimit,   // applied limit
   input wire logic [3:0]       railEnable,     // rails on
   input wire logic             lowVoltageMode, // low voltage mode
   input wire logic             batteryBrownoutEnable, // detector on
   input wire logic             bandgapOn,      // bandgap running
   input wire logic             retentionSample, // resample strobe
   input wire logic             busPoweredRegulator // bus regulator
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // control write taken while ack is still low
   wire ctlWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
                && wb_adr_i == 8'h00 && wb_sel_i[0];
   sequence sTake; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence sLvOff; ctlWr && !wb_dat_i[2]; endsequence
   chk_ack_next: assert property (sTake |=> wb_ack_o)
      else $error("no ack after a request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   chk_lv_rails: assert property (
      lowVoltageMode |-> railEnable[1:0] == 2'b00)
      else $error("1.8 V rails on in low voltage mode");
   chk_lv_hold: assert property (
      lowVoltageMode && !ctlWr |=> lowVoltageMode)
      else $error("low voltage mode left without software");
   chk_lv_clear: assert property (sLvOff |=> !lowVoltageMode)
      else $error("low voltage mode not forced off");
   chk_lv_bod: assert property (
      $rose(lowVoltageMode) |-> $past(batteryBrownoutEnable))
      else $error("low voltage mode without detector enabled");
   // limit moves one step at most and never wraps; the clamp that follows
   // a register write or a change of mode is a jump of its own, left out
   chk_limit_step: assert property (
      !lowVoltageMode && $past(!lowVoltageMode) && !$past(reset)
      && !$past(wb_ack_o) |-> currentLimit == $past(currentLimit)
      || {1'b0, currentLimit} == {1'b0, $past(currentLimit)} + 1'b1
      || {1'b0, $past(currentLimit)} == {1'b0, currentLimit} + 1'b1)
      else $error("current limit jumped");
   chk_charge_one: assert property (chargeReq |=> !chargeReq)
      else $error("charge slot longer than one cycle");
   chk_bus_sync: assert property (
      !$past(reset) && !$past(reset, 2)
      |-> busPoweredRegulator == $past(busAboveBat, 2))
      else $error("bus regulator does not follow bus sense");
   chk_sample_bg: assert property (retentionSample |-> bandgapOn)
      else $error("resample without bandgap");
   chk_bg_stop: assert property (
      $fell(bandgapOn) && !$past(reset) |-> $past(retentionSample))
      else $error("bandgap stopped without a resample");
endmodule // simo_asserts

bind simo_dcdc_ctrl simo_asserts #(.LIM_W(LIM_W)) u_chk (
   .clk(clk), .reset(reset), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .busAboveBat(busAboveBat),
   .chargeReq(chargeReq), .currentLimit(currentLimit),
   .railEnable(railEnable), .lowVoltageMode(lowVoltageMode),
   .batteryBrownoutEnable(batteryBrownoutEnable), .bandgapOn(bandgapOn),
   .retentionSample(retentionSample),
   .busPoweredRegulator(busPoweredRegulator));

/* File: verif/simo_dcdc_digital_controller_bench.sv */
// Purpose: self-checking bench of the converter controller
// Assumes: ce held high; long hold threshold shortened through the register
// Notes:   comparator pulses are one cycle wide, enough for the synchroniser
`timescale 1ns/1ps
`include "simo_cfg.svh"
module simo_dcdc_digital_controller_bench;
   logic        clk = 1'b0, reset = 1'b1, ce = 1'b1, wb_we_i = 1'b0;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, batLow = 1'b0;
   logic        busAboveBat = 1'b0, sleepTick = 1'b0, seenBg, seenSmp;
   logic [7:0]  wb_adr_i = 8'h00, order;
   logic [31:0] wb_dat_i = 32'h0000_0000, rd;
   logic [3:0]  wb_sel_i = 4'h0, belowMin = 4'h0;
   wire  [31:0] wb_dat_o;
   wire         wb_ack_o, chargeReq, lowVoltageMode, brownoutIrq, bandgapOn;
   wire         batteryBrownoutEnable, retentionSample, busPoweredRegulator;
   wire  [1:0]  chargeRail;
   wire  [4:0]  currentLimit;
   wire  [3:0]  railEnable;
   int          badCount = 0, nTests = 0, k;

   // 40 MHz clock
   always #12.5 clk = ~clk;

   simo_dcdc_ctrl u_dut (.clk, .reset, .ce, .wb_adr_i, .wb_dat_i, .wb_dat_o,
      .wb_we_i, .wb_sel_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .belowMin,
      .batLow, .busAboveBat, .sleepTick, .chargeReq, .chargeRail,
      .currentLimit, .railEnable, .lowVoltageMode, .batteryBrownoutEnable,
      .brownoutIrq, .bandgapOn, .retentionSample, .busPoweredRegulator);

   task automatic endSim;
      $display("checks %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      nTests++;
      if (got !== exp) begin
         badCount++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask

   // one classic cycle held until ack is sampled high
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n >= 20) begin
         $display("unexpected at %0t: bus timeout", $time);
         badCount++;
         endSim();
      end
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask

   // gap sets how long the rail stays above its minimum
   task automatic pulses(input int n, input int gap);
      repeat (n) begin
         @(posedge clk) belowMin <= 4'h4;
         @(posedge clk) belowMin <= 4'h0;
         repeat (gap) @(posedge clk);
      end
   endtask

   task automatic tReset;
      chk(32'(currentLimit), 32'h0000_0010);
      chk(32'({lowVoltageMode, brownoutIrq, railEnable, chargeReq}), 0);
      rdc(`SIMO_PRIO_ADDR, 32'h0000_00E4);
      rdc(`SIMO_LIMIT_ADDR, 32'h0000_0010);
      rdc(`SIMO_LVLIM_ADDR, 32'h0000_0008);
      rdc(`SIMO_THRESH_ADDR, 32'h0100_0010);
      rdc(8'h40, 32'h0000_0000);
   endtask

   task automatic tBod;
      bus(1'b1, `SIMO_CTRL_ADDR, 32'h0000_00F4);
      batLow <= 1'b1;
      repeat (8) @(posedge clk);
      chk(32'({lowVoltageMode, brownoutIrq}), 0);
      bus(1'b1, `SIMO_CTRL_ADDR, 32'h0000_00F6);
      repeat (8) @(posedge clk);
      chk(32'({lowVoltageMode, batteryBrownoutEnable}), 32'h3);
      chk(32'(railEnable), 32'h0000_000C);
      chk(32'(currentLimit <= 5'h08), 32'h1);
      chk(32'(brownoutIrq), 32'h1);
      rdc(`SIMO_STATUS_ADDR, 32'h0000_0007);
      batLow <= 1'b0;
      repeat (8) @(posedge clk);
      chk(32'(lowVoltageMode), 32'h1);
      // replacement LDOs are on by the indication, so the rails may go off
      bus(1'b1, `SIMO_CTRL_ADDR, 32'h0000_0006);
      chk(32'({lowVoltageMode, railEnable}), 32'h0000_0010);
      bus(1'b1, `SIMO_IRQCLR_ADDR, 32'h0000_0001);
      repeat (2) @(posedge clk);
      chk(32'(brownoutIrq), 0);
      bus(1'b1, `SIMO_IRQMASK_ADDR, 32'h0000_0001);
      batLow <= 1'b1;
      repeat (8) @(posedge clk);
      chk(32'(brownoutIrq), 0);
      batLow <= 1'b0;
      bus(1'b1, `SIMO_CTRL_ADDR, 32'h0000_00F2);
      repeat (2) @(posedge clk);
      chk(32'({lowVoltageMode, railEnable}), 32'h0000_000F);
      bus(1'b1, `SIMO_CTRL_ADDR, 32'h0000_00F6);
      repeat (8) @(posedge clk);
      chk(32'(lowVoltageMode), 0);
   endtask

   // one comparator pulse, then count the charge slots and their rails
   task automatic charges(input logic [3:0] low);
      @(posedge clk) belowMin <= low;
      @(posedge clk) belowMin <= 4'h0;
      k = 0;
      order = 8'h00;
      repeat (60) begin
         @(posedge clk);
         if (chargeReq === 1'b1) begin
            order = {order[5:0], chargeRail};
            k++;
         end
      end
   endtask

   task automatic tCharge;
      bus(1'b1, `SIMO_CTRL_ADDR, 32'h0000_00F0);
      bus(1'b1, `SIMO_PRIO_ADDR, 32'h0000_001B);
      charges(4'hF);
      chk(32'(k), 32'h0000_0004);
      chk(32'(order), 32'h0000_00E4);
      charges(4'h5);
      chk(32'(k), 32'h0000_0002);
      chk(32'(order), 32'h0000_0008);
   endtask

   task automatic tLimit;
      bus(1'b1, `SIMO_THRESH_ADDR, 32'h0040_0010);
      bus(1'b1, `SIMO_LIMIT_ADDR, 32'h0000_001F);
      bus(1'b1, `SIMO_CTRL_ADDR, 32'h0000_00F1);
      pulses(40, 8);
      chk(32'(currentLimit), 32'h0000_001F);
      pulses(40, 120);
      chk(32'(currentLimit), 0);
   endtask

   // one sleep tick every four cycles; notes bandgap and resample activity
   task automatic ticks(input int n);
      seenBg = 1'b0;
      seenSmp = 1'b0;
      repeat (2 * n) begin
         repeat (2) @(posedge clk);
         sleepTick <= ~sleepTick;
         seenBg = seenBg | (bandgapOn === 1'b1);
         seenSmp = seenSmp | (retentionSample === 1'b1);
      end
   endtask

   task automatic tSleep;
      bus(1'b1, `SIMO_SLPTIM_ADDR, 32'h0000_0002);
      ticks(40);
      chk(32'({seenBg, seenSmp}), 32'h3);
      rdc(`SIMO_SLPTIM_ADDR, 32'h0000_0002);
      bus(1'b1, `SIMO_SLPTIM_ADDR, 32'h0000_0000);
      ticks(4);
      ticks(20);
      chk(32'({seenBg, seenSmp}), 0);
      chk(32'(busPoweredRegulator), 0);
      busAboveBat <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(busPoweredRegulator), 32'h1);
   endtask

   // reset for two cycles, then the scenarios in turn
   initial begin
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      tReset;
      tBod;
      tCharge;
      tLimit;
      tSleep;
      endSim;
   end
endmodule // simo_dcdc_digital_controller_bench
